//--- verilog/seq_pkg.sv
package seq_pkg;

  localparam int PC_W      = 10;
  localparam int ACC_W     = 4;
  localparam int RAM_AW    = 5;
  localparam int RAM_DW    = 5;
  localparam int RAM_WORDS = 32;
  localparam int ROM_STEPS = 1002;
  localparam int LVL_W     = 2;
  localparam int PIN_W     = 4;

  // Instruction word fields
  localparam int OP_MSB    = 9;
  localparam int OP_LSB    = 6;
  localparam int ARG_MSB   = 5;
  localparam int HALT_BIT  = 0;
  localparam int PTEST_LVL = 4;
  localparam int PTEST_SRC = 5;
  localparam int ALU_MSB   = 5;
  localparam int ALU_LSB   = 4;

  localparam logic [PC_W-1:0]   PC_RESET      = 10'h000;
  localparam logic [PC_W-1:0]   ROM_LAST      = 10'(ROM_STEPS - 1);
  localparam logic [PC_W-1:0]   STEP_INC      = 10'h001;
  localparam logic [PC_W-1:0]   CALL_SAVE_INC = 10'h001;
  localparam logic [PC_W-1:0]   RET_INC       = 10'h002;
  localparam logic [LVL_W-1:0]  LVL_RESET     = 2'h0;
  localparam logic [LVL_W-1:0]  LVL_MAX       = 2'h3;
  localparam logic [LVL_W-1:0]  LVL_STEP      = 2'h1;
  localparam logic [RAM_AW-1:0] STACK_TOP     = 5'h0f;
  localparam logic [RAM_AW-1:0] HI_BANK       = 5'h10;
  localparam logic [RAM_AW-1:0] PTR_ADDR      = 5'h00;
  localparam logic [ACC_W-1:0]  ACC_RESET     = 4'h0;
  localparam logic [ACC_W-1:0]  ACC_ONES      = 4'hf;
  localparam logic [ACC_W-1:0]  ACC_ONE       = 4'h1;

  localparam logic [3:0] OP_NOP  = 4'h0;
  localparam logic [3:0] OP_JUMP = 4'h1;
  localparam logic [3:0] OP_JCY  = 4'h2;
  localparam logic [3:0] OP_JST  = 4'h3;
  localparam logic [3:0] OP_CALL = 4'h4;
  localparam logic [3:0] OP_EXIT = 4'h5;
  localparam logic [3:0] OP_LDI  = 4'h6;
  localparam logic [3:0] OP_INC  = 4'h7;
  localparam logic [3:0] OP_ROTL = 4'h8;
  localparam logic [3:0] OP_ONES = 4'h9;
  localparam logic [3:0] OP_PIN  = 4'ha;
  localparam logic [3:0] OP_LDM  = 4'hb;
  localparam logic [3:0] OP_STM  = 4'hc;
  localparam logic [3:0] OP_TBL  = 4'hd;
  localparam logic [3:0] OP_JMPM = 4'he;
  localparam logic [3:0] OP_ALU  = 4'hf;

  localparam logic [1:0] ALU_ADD = 2'h0;
  localparam logic [1:0] ALU_AND = 2'h1;
  localparam logic [1:0] ALU_OR  = 2'h2;
  localparam logic [1:0] ALU_XOR = 2'h3;

  // Synchroniser vector: {all_clear_n, wake_in, serial_in, pin_state}
  localparam int              SYNC_W     = 7;
  localparam int              SYNC_AC    = 6;
  localparam int              SYNC_WAKE  = 5;
  localparam int              SYNC_SER   = 4;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 7'h40;

  typedef enum logic [1:0] {ST_FETCH, ST_TARGET, ST_TABLE, ST_HALT} seq_state_t;

endpackage : seq_pkg

//--- verilog/data_store_if.sv
`timescale 1ns/10ps
interface data_store_if;
  logic [4:0] rd_addr;
  logic [4:0] rd_data;
  logic [1:0] stk_idx;
  logic [9:0] stk_rd;
  logic       stk_we;
  logic [9:0] stk_wd;
  logic       wr_en;
  logic [4:0] wr_addr;
  logic [4:0] wr_data;
  logic [7:0] ptr;

  modport core
  (
    output rd_addr, stk_idx, stk_we, stk_wd, wr_en, wr_addr, wr_data,
    input  rd_data, stk_rd, ptr
  );
  modport store
  (
    input  rd_addr, stk_idx, stk_we, stk_wd, wr_en, wr_addr, wr_data,
    output rd_data, stk_rd, ptr
  );
endinterface : data_store_if

//--- verilog/data_store.sv
`timescale 1ns/10ps
module data_store
  import seq_pkg::*;
(
  input wire logic        sys_clk,
  data_store_if.store     mem
);

  logic [RAM_DW-1:0] ram_r [RAM_WORDS];
  logic [RAM_AW-1:0] slot_lo;
  logic [RAM_AW-1:0] slot_hi;

  // Stack slot for a level, counting down from the top row
  function automatic logic [RAM_AW-1:0] stack_slot(input logic [LVL_W-1:0] idx);
    stack_slot = STACK_TOP - {3'h0, idx};
  endfunction : stack_slot

  always_comb
  begin
    slot_lo     = stack_slot(mem.stk_idx);
    slot_hi     = slot_lo | HI_BANK;
    mem.rd_data = ram_r[mem.rd_addr];
    mem.stk_rd  = {ram_r[slot_hi], ram_r[slot_lo]};
    mem.ptr     = {ram_r[PTR_ADDR | HI_BANK][ACC_W-1:0], ram_r[PTR_ADDR][ACC_W-1:0]};
  end

  // No reset: contents survive reset and all-clear
  always_ff @(posedge sys_clk)
  begin
    if (mem.wr_en)
    begin
      ram_r[mem.wr_addr] <= mem.wr_data;
    end
    if (mem.stk_we)
    begin
      ram_r[slot_hi] <= mem.stk_wd[PC_W-1:RAM_DW];
      ram_r[slot_lo] <= mem.stk_wd[RAM_DW-1:0];
    end
  end

endmodule : data_store

//--- verilog/program_sequencer_core.sv
// Notes on behaviour
// - 10-bit counter advances by instruction length
// - Jumps load target from immediate or memory
// - Call saves counter plus one, then jumps
// - Return loads saved value plus two
// - Reset or all-clear zeroes the counter
// - 2-bit stack level counts calls and returns
// - Level zero selects top word; higher go lower
// - Stack overflow or underflow resets the counter
// - Fetch 10-bit words from 1002-step program memory
// - 32 by 5 data memory, kept through reset
// - Table address is pointer pair plus page
// - 4-bit accumulator, cleared to zero by reset
// - 4-bit ALU works on accumulator data
// - Pin test match sets status flag
// - Increment or rotate carry sets carry flag
// - All-ones test sets carry flag
// - Oscillator-stop mode only sets clock_stopped while halted
// - Two control bits give table address top
// - Rotate feeds top bit or serial pin
`timescale 1ns/10ps
module program_sequencer_core
  import seq_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             all_clear_n,
  output logic [PC_W-1:0]       rom_addr,
  input  wire logic [PC_W-1:0]  rom_data,
  input  wire logic [PIN_W-1:0] pin_state,
  input  wire logic             serial_in,
  input  wire logic             wake_in,
  input  wire logic [1:0]       table_page,
  input  wire logic             rl_from_serial,
  input  wire logic             osc_stop_select,
  output logic [ACC_W-1:0]      acc,
  output logic                  carry_flag,
  output logic                  status_flag,
  output logic [LVL_W-1:0]      stack_level,
  output logic                  cpu_fault,
  output logic                  clock_stopped,
  output logic                  halted
);

  data_store_if mem ();

  data_store u_store
  (
    .sys_clk (sys_clk),
    .mem     (mem.store)
  );

  // Three-stage input synchronisers
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] s1_r, s2_r, s3_r, filt_r;
  logic [SYNC_W-1:0] s1_nxt, s2_nxt, s3_nxt, filt_nxt;

  assign sync_in = {all_clear_n, wake_in, serial_in, pin_state};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++)
    begin : g_sync
      always_comb
      begin
        s1_nxt[gi]   = sync_in[gi];
        s2_nxt[gi]   = s1_r[gi];
        s3_nxt[gi]   = s2_r[gi];
        filt_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : filt_r[gi];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      s1_r   <= SYNC_RESET;
      s2_r   <= SYNC_RESET;
      s3_r   <= SYNC_RESET;
      filt_r <= SYNC_RESET;
    end
    else
    begin
      s1_r   <= s1_nxt;
      s2_r   <= s2_nxt;
      s3_r   <= s3_nxt;
      filt_r <= filt_nxt;
    end
  end

  logic clear_core;
  assign clear_core = !rstn || !filt_r[SYNC_AC];

  // Counter step that wraps past the last program step
  function automatic logic [PC_W-1:0] pc_add(input logic [PC_W-1:0] base,
                                              input logic [PC_W-1:0] step);
    logic [PC_W:0] sum;
    sum = {1'b0, base} + {1'b0, step};
    if (sum > {1'b0, ROM_LAST})
      pc_add = PC_W'(sum - {1'b0, ROM_LAST} - 11'h001);
    else
      pc_add = sum[PC_W-1:0];
  endfunction : pc_add

  // Sequencer state
  seq_state_t        state_r, state_nxt;
  logic [PC_W-1:0]   pc_r, pc_nxt;
  logic [PC_W-1:0]   addr_r, addr_nxt;
  logic [3:0]        op_r, op_nxt;
  logic [LVL_W-1:0]  lvl_r, lvl_nxt;
  logic [ACC_W-1:0]  acc_r, acc_nxt;
  logic              c_r, c_nxt;
  logic              f_r, f_nxt;
  logic              fault_r, fault_nxt;
  logic              stop_r, stop_nxt;

  logic [3:0]        op;
  logic [ARG_MSB:0]  arg;
  logic [ACC_W:0]    inc_sum;
  logic              rl_in;
  logic              pin_hit;
  logic [ACC_W-1:0]  alu_res;
  logic [ACC_W-1:0]  imm;

  assign op  = rom_data[OP_MSB:OP_LSB];
  assign arg = rom_data[ARG_MSB:0];
  assign imm = arg[ACC_W-1:0];

  always_comb
  begin
    inc_sum  = {1'b0, acc_r} + {1'b0, ACC_ONE};
    rl_in    = rl_from_serial ? filt_r[SYNC_SER] : acc_r[ACC_W-1];
    if (arg[PTEST_SRC])
      pin_hit = (filt_r[SYNC_SER] == arg[PTEST_LVL]);
    else
      pin_hit = ((filt_r[PIN_W-1:0] & imm) == (arg[PTEST_LVL] ? imm : ACC_RESET));
    unique case (arg[ALU_MSB:ALU_LSB])
      ALU_ADD: alu_res = acc_r + imm;
      ALU_AND: alu_res = acc_r & imm;
      ALU_OR:  alu_res = acc_r | imm;
      ALU_XOR: alu_res = acc_r ^ imm;
    endcase
  end

  always_comb
  begin
    state_nxt      = state_r;
    pc_nxt         = pc_r;
    op_nxt         = op_r;
    lvl_nxt        = lvl_r;
    acc_nxt        = acc_r;
    c_nxt          = c_r;
    f_nxt          = f_r;
    fault_nxt      = 1'b0;
    stop_nxt       = stop_r;
    mem.rd_addr    = arg[RAM_AW-1:0];
    mem.stk_idx    = lvl_r;
    mem.stk_we     = 1'b0;
    mem.stk_wd     = pc_add(pc_r, CALL_SAVE_INC);
    mem.wr_en      = 1'b0;
    mem.wr_addr    = arg[RAM_AW-1:0];
    mem.wr_data    = {1'b0, acc_r};
    unique case (state_r)
      ST_FETCH:
      begin
        pc_nxt = pc_add(pc_r, STEP_INC);
        unique case (op)
          OP_NOP:
          begin
            if (arg[HALT_BIT])
            begin
              state_nxt = ST_HALT;
              stop_nxt  = osc_stop_select;
            end
          end
          OP_JUMP, OP_JCY, OP_JST, OP_CALL:
          begin
            op_nxt    = op;
            pc_nxt    = pc_r;
            state_nxt = ST_TARGET;
          end
          OP_EXIT:
          begin
            mem.stk_idx = lvl_r - LVL_STEP;
            if (lvl_r == LVL_RESET)
            begin
              pc_nxt    = PC_RESET;
              lvl_nxt   = LVL_RESET;
              fault_nxt = 1'b1;
            end
            else
            begin
              lvl_nxt = lvl_r - LVL_STEP;
              pc_nxt  = pc_add(mem.stk_rd, RET_INC);
            end
          end
          OP_LDI:  acc_nxt = imm;
          OP_INC:
          begin
            acc_nxt = inc_sum[ACC_W-1:0];
            c_nxt   = inc_sum[ACC_W];
          end
          OP_ROTL:
          begin
            acc_nxt = {acc_r[ACC_W-2:0], rl_in};
            c_nxt   = acc_r[ACC_W-1];
          end
          OP_ONES: c_nxt = (acc_r == ACC_ONES);
          OP_PIN:  f_nxt = pin_hit;
          OP_LDM:  acc_nxt = mem.rd_data[ACC_W-1:0];
          OP_STM:  mem.wr_en = 1'b1;
          OP_TBL:  state_nxt = ST_TABLE;
          OP_JMPM: pc_nxt = {pc_r[PC_W-1:RAM_DW], mem.rd_data};
          OP_ALU:  acc_nxt = alu_res;
        endcase
      end
      ST_TARGET:
      begin
        state_nxt = ST_FETCH;
        pc_nxt    = pc_add(pc_r, RET_INC);
        unique case (op_r)
          OP_JUMP: pc_nxt = rom_data;
          OP_JCY:  pc_nxt = c_r ? rom_data : pc_add(pc_r, RET_INC);
          OP_JST:  pc_nxt = f_r ? rom_data : pc_add(pc_r, RET_INC);
          OP_CALL:
          begin
            if (lvl_r == LVL_MAX)
            begin
              pc_nxt    = PC_RESET;
              lvl_nxt   = LVL_RESET;
              fault_nxt = 1'b1;
            end
            else
            begin
              mem.stk_we = 1'b1;
              lvl_nxt    = lvl_r + LVL_STEP;
              pc_nxt     = rom_data;
            end
          end
          default: pc_nxt = pc_add(pc_r, RET_INC);
        endcase
      end
      ST_TABLE:
      begin
        acc_nxt   = rom_data[ACC_W-1:0];
        state_nxt = ST_FETCH;
      end
      ST_HALT:
      begin
        if (filt_r[SYNC_WAKE])
        begin
          state_nxt = ST_FETCH;
          stop_nxt  = 1'b0;
        end
      end
    endcase
    // Program memory address for the next cycle
    if (state_nxt == ST_TABLE)
      addr_nxt = {table_page, mem.ptr};
    else if (state_nxt == ST_TARGET)
      addr_nxt = pc_add(pc_r, STEP_INC);
    else
      addr_nxt = pc_nxt;
  end

  always_ff @(posedge sys_clk)
  begin
    if (clear_core)
    begin
      state_r <= ST_FETCH;
      pc_r    <= PC_RESET;
      addr_r  <= PC_RESET;
      op_r    <= OP_NOP;
      lvl_r   <= LVL_RESET;
      acc_r   <= ACC_RESET;
      c_r     <= 1'b0;
      f_r     <= 1'b0;
      fault_r <= 1'b0;
      stop_r  <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      pc_r    <= pc_nxt;
      addr_r  <= addr_nxt;
      op_r    <= op_nxt;
      lvl_r   <= lvl_nxt;
      acc_r   <= acc_nxt;
      c_r     <= c_nxt;
      f_r     <= f_nxt;
      fault_r <= fault_nxt;
      stop_r  <= stop_nxt;
    end
  end

  assign rom_addr      = addr_r;
  assign acc           = acc_r;
  assign carry_flag    = c_r;
  assign status_flag   = f_r;
  assign stack_level   = lvl_r;
  assign cpu_fault     = fault_r;
  assign clock_stopped = stop_r;
  assign halted        = (state_r == ST_HALT);

endmodule : program_sequencer_core

//--- tb/prog_rom.sv
`timescale 1ns/10ps
module prog_rom
  import seq_pkg::*;
(
  input  wire logic [PC_W-1:0] rom_addr,
  output logic      [PC_W-1:0] rom_data
);
  logic [PC_W-1:0] mem [1024];
  // Program and table words, answered in the same cycle
  assign rom_data = mem[rom_addr];
endmodule : prog_rom

//--- tb/seq_core_asserts.sv
`timescale 1ns/10ps
module seq_core_asserts
  import seq_pkg::*;
(
  input wire logic             sys_clk,
  input wire logic             rstn,
  input wire logic             all_clear_n,
  input wire logic [PC_W-1:0]  rom_addr,
  input wire logic [PC_W-1:0]  rom_data,
  input wire logic [ACC_W-1:0] acc,
  input wire logic             carry_flag,
  input wire logic [LVL_W-1:0] stack_level,
  input wire logic             cpu_fault,
  input wire logic             halted
);
  logic [3:0] ac_r, ac_nxt;
  logic       slow_r, slow_nxt;
  wire  [3:0] op     = rom_data[OP_MSB:OP_LSB];
  wire        run_ok = !halted && !slow_r;
  // Clear pin history; multi-cycle op marker
  always_comb
  begin
    ac_nxt   = rstn ? {ac_r[2:0], all_clear_n} : 4'hf;
    slow_nxt = rstn && run_ok && (op inside {OP_JUMP, OP_JCY, OP_JST, OP_CALL, OP_TBL});
  end
  always_ff @(posedge sys_clk)
  begin
    ac_r   <= ac_nxt;
    slow_r <= slow_nxt;
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn || !all_clear_n || ac_r != 4'hf);

  reset_clear_a : assert property (disable iff (1'b0)
    !rstn |=> rom_addr == PC_RESET && stack_level == LVL_RESET && !halted)
    else $error("reset did not clear core");
  fault_pulse_a : assert property (cpu_fault |=> !cpu_fault)
    else $error("fault longer than one cycle");
  level_step_a : assert property ($changed(stack_level) |->
    stack_level == LVL_RESET || 2'(stack_level - $past(stack_level)) inside {2'h1, 2'h3})
    else $error("stack level jumped");
  halt_freeze_a : assert property (halted ##1 halted |->
    $stable(rom_addr) && $stable(acc) && $stable(stack_level))
    else $error("state moved while halted");
  ones_carry_a : assert property (run_ok && op == OP_ONES |=>
    carry_flag == ($past(acc) == ACC_ONES))
    else $error("all-ones test carry wrong");
  inc_carry_a : assert property (run_ok && op == OP_INC |=>
    acc == 4'($past(acc) + ACC_ONE) && carry_flag == ($past(acc) == ACC_ONES))
    else $error("increment wrong");
  call_push_a : assert property (run_ok && op == OP_CALL && stack_level != LVL_MAX |->
    ##2 stack_level == 2'($past(stack_level, 2) + LVL_STEP) && rom_addr == $past(rom_data))
    else $error("call did not enter target");
  return_under_a : assert property (run_ok && op == OP_EXIT && stack_level == LVL_RESET |->
    ##[1:2] cpu_fault)
    else $error("return underflow not caught");
  cover property (run_ok && op == OP_CALL);
  cover property (cpu_fault);
  cover property (halted ##1 halted);
endmodule : seq_core_asserts

bind program_sequencer_core seq_core_asserts u_asserts (.sys_clk, .rstn, .all_clear_n,
  .rom_addr, .rom_data, .acc, .carry_flag, .stack_level, .cpu_fault, .halted);

//--- tb/program_sequencer_core_bench.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module program_sequencer_core_bench;
  import seq_pkg::*;
  logic sys_clk = 1'b0, rstn = 1'b0, all_clear_n = 1'b1, serial_in = 1'b0, wake_in = 1'b0;
  logic rl_from_serial = 1'b0, osc_stop_select = 1'b0;
  logic [1:0] table_page = 2'h0;
  logic [PIN_W-1:0] pin_state = 4'h0;
  logic [PC_W-1:0] rom_addr, rom_data;
  logic [ACC_W-1:0] acc;
  logic [LVL_W-1:0] stack_level;
  logic carry_flag, status_flag, cpu_fault, clock_stopped, halted;
  int n_mismatch = 0, total_checks = 0;
  typedef struct {int k; logic [9:0] v;} note_t;
  note_t q[$];
  event ev;
  logic [9:0] seen [6];
  string nm [6] = '{"acc", "carry", "level", "addr", "status", "stopped"};
  always #5 sys_clk = ~sys_clk;
  assign seen = '{10'(acc), 10'(carry_flag), 10'(stack_level), rom_addr, 10'(status_flag),
    10'(clock_stopped)};
  program_sequencer_core u_dut (.sys_clk, .rstn, .all_clear_n, .rom_addr, .rom_data,
    .pin_state, .serial_in, .wake_in, .table_page, .rl_from_serial, .osc_stop_select,
    .acc, .carry_flag, .status_flag, .stack_level, .cpu_fault, .clock_stopped, .halted);
  prog_rom u_rom (.rom_addr, .rom_data);
  // Oldest note against the output it names
  always @(ev)
    while (q.size() > 0)
    begin
      `CHK(nm[q[0].k], q[0].v, seen[q[0].k])
      void'(q.pop_front());
    end
  task automatic note(input int k, input logic [9:0] v);
    q.push_back('{k, v});
    -> ev;
  endtask : note
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic load(input logic [9:0] p[$], input int base);
    if (base == 0)
      for (int i = 0; i < 1024; i++)
        u_rom.mem[i] = 10'h001;
    foreach (p[i])
      u_rom.mem[base+i] = p[i];
  endtask : load
  // 0: reset, run to halt; 1: reset, run to fault; 2: run to halt
  task automatic go(input int f);
    if (f < 2)
    begin
      rstn = 1'b0;
      repeat (2) @(negedge sys_clk);
      rstn = 1'b1;
    end
    for (int i = 0; i < 300; i++)
    begin
      @(negedge sys_clk);
      if ((f == 1 ? cpu_fault : halted) === 1'b1)
        return;
    end
    `CHK("wait", 1'b1, 1'b0)
    stop_test();
  endtask : go
  initial
  begin
    logic [3:0] a, b, m, lo, hi, e, t, x;
    logic [1:0] pg;
    logic [9:0] w, v;
    bit s, c, lv;
    a = 4'($urandom(4));
    repeat (5) @(negedge sys_clk);
    note(3, 10'h000);
    note(2, 10'h000);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      a = 4'($urandom);
      b = 4'($urandom);
      e = i == 0 ? a + b : i == 1 ? a & b : i == 2 ? a | b : a ^ b;
      load({10'h040, 10'h008}, 0);
      load({10'h180 | 10'(a), 10'h3c0 | 10'(i) << 4 | 10'(b), 10'h001}, 8);
      go(0);
      note(0, 10'(e));
    end
    $display("test alu done");
    for (int i = 0; i < 9; i++)
    begin
      a = i < 3 ? 4'hf : 4'($urandom);
      s = 1'($urandom);
      c = 1'($urandom);
      rl_from_serial = s;
      serial_in = c;
      w = i % 3 == 0 ? 10'h240 : i % 3 == 1 ? 10'h1c0 : 10'h200;
      e = i % 3 == 0 ? a : i % 3 == 1 ? a + 4'h1 : {a[2:0], s ? c : a[3]};
      load({10'h000, 10'h000, 10'h000, 10'h000, 10'h180 | 10'(a), w, 10'h001}, 0);
      go(0);
      note(0, 10'(e));
      note(1, 10'(i % 3 == 2 ? a[3] : a == 4'hf));
    end
    $display("test flags done");
    for (int i = 0; i < 6; i++)
    begin
      m = 4'($urandom);
      pin_state = 4'($urandom);
      serial_in = 1'($urandom);
      s = i > 3;
      c = 1'($urandom);
      load({10'h000, 10'h000, 10'h000, 10'h000, 10'h280 | 10'({s, c, m}), 10'h001}, 0);
      go(0);
      note(4, 10'(s ? serial_in == c : (pin_state & m) == (c ? m : 4'h0)));
    end
    $display("test status done");
    for (int i = 0; i < 4; i++)
    begin
      x = i[0] ? 4'hf : 4'($urandom);
      serial_in = 1'($urandom);
      lv = serial_in ^ i[1];
      load({10'h180 | 10'(x), 10'h240, 10'h180, 10'h000, 10'h2a0 | 10'(lv) << 4, 10'h080,
        10'h008, 10'h3e1, 10'h0c0, 10'h00b, 10'h3e2, 10'h001}, 0);
      go(0);
      note(0, 10'({serial_in != lv, x != 4'hf}));
    end
    $display("test jump done");
    load({10'h100, 10'h010, 10'h180, 10'h001}, 0);
    load({10'h2cf, 10'h100, 10'h020, 10'h001, 10'h140}, 16);
    load({10'h140}, 32);
    go(0);
    note(2, 10'h000);
    note(0, 10'h001);
    $display("test call done");
    for (int i = 0; i < 2; i++)
    begin
      if (i == 0)
        load({10'h040, 10'h002, 10'h140}, 0);
      else
        load({10'h100, 10'h002, 10'h100, 10'h004, 10'h100, 10'h006, 10'h100, 10'h008}, 0);
      go(1);
      note(2, 10'h000);
      note(3, 10'h000);
    end
    $display("test fault done");
    lo = 4'($urandom);
    hi = 4'($urandom);
    pg = 2'(1 + $urandom % 3);
    v = 10'($urandom);
    table_page = pg;
    load({10'h180 | 10'(lo), 10'h300, 10'h180 | 10'(hi), 10'h310, 10'h340, 10'h001}, 0);
    u_rom.mem[{pg, hi, lo}] = v;
    go(0);
    note(0, 10'(v[3:0]));
    load({10'h2c0, 10'h001}, 0);
    go(0);
    note(0, 10'(lo));
    t = 4'(6 + $urandom % 10);
    x = 4'($urandom);
    load({10'h180 | 10'(t), 10'h303, 10'h180 | 10'(x), 10'h383, 10'h180 | {6'h0, ~x}, 10'h001},
      0);
    go(0);
    note(0, 10'(x));
    note(3, 10'(t) + 10'h001);
    $display("test table done");
    osc_stop_select = 1'b1;
    load({10'h001, 10'h186, 10'h001}, 0);
    go(0);
    note(5, 10'h001);
    wake_in = 1'b1;
    repeat (8) @(negedge sys_clk);
    wake_in = 1'b0;
    repeat (8) @(negedge sys_clk);
    go(2);
    note(0, 10'h006);
    all_clear_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    note(3, 10'h000);
    note(5, 10'h000);
    all_clear_n = 1'b1;
    go(2);
    $display("test standby done");
    stop_test();
  end
endmodule : program_sequencer_core_bench
